// file: core/tiv_pkg.sv
// Constants, types and helper functions for the TMR input vote and I/O exchange
// Functional notes
// - Leg polls the one module leg on its own bus, refreshes input table
// - Master-slave I/O bus, leg is master
// - Write frames and read answers carry a checked CRC
// - Input exchange retried three times, then de-energized
// - Open, shorted or corrupt bus de-energizes entries
// - Scan start snapshot sent to both peers
// - Each leg votes its own table independently
// - Bad or missing peer copy becomes de-energized
// - Digital point energized only on two-of-three
// - Anything short of positive vote means de-energized
// - Analog point takes median of three legs
// - Large analog spread raises diagnostic alarm
// - Outputs computed from voted table into output table
// - Output table sent per module over bus
// - Module leg de-energizes after failed output retries
// - Module watchdog de-energizes on lost or absent traffic
// - Legs aligned once per scan by sync
// - Chassis alarm for config, module, load, cable faults
// - Persistent leg disagreement raises diagnostic alarm
package tiv_pkg;

    // =====================================================================
    // Widths
    localparam int DIG_W      = 8;
    localparam int AN_W       = 8;
    localparam int WORD_W     = 16;
    localparam int CRC_W      = 8;
    localparam int ADDR_W     = 2;
    localparam int ALARM_W    = 6;
    localparam int WDOG_CNT_W = 14;

    // =====================================================================
    // Bus addresses, codes and values
    localparam logic [CRC_W-1:0]  CRC_POLY    = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_IN     = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_OUT    = 2'h1;
    localparam logic [2:0]        MAX_RETRY   = 3'h3;
    localparam logic [2:0]        FAIL_LIMIT  = 3'h4;
    localparam logic [WORD_W-1:0] DEENERGIZED = 16'h0000;
    localparam logic [AN_W-1:0]   AN_DEV_LIMIT  = 8'h10;
    localparam logic [3:0]        PERSIST_SCANS = 4'h4;

    // =====================================================================
    // Synchroniser bit positions
    localparam int SYN_SCAN = 0;
    localparam int SYN_PA   = 1;
    localparam int SYN_PB   = 2;
    localparam int SYN_ALM  = 3;
    localparam int SYN_W    = SYN_ALM + ALARM_W;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RESP_TIMEOUT_NS = 2000;
    localparam logic [7:0] RESP_TIMEOUT_CYC = 8'(RESP_TIMEOUT_NS / CLK_PERIOD_NS);
    localparam int PEER_TIMEOUT_NS = 20000;
    localparam logic [10:0] PEER_TIMEOUT_CYC = 11'(PEER_TIMEOUT_NS / CLK_PERIOD_NS);
    localparam int WDOG_TIMEOUT_US = 100;
    localparam int WDOG_DEFAULT_CYC = WDOG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

    // =====================================================================
    // Master sequencer states
    typedef enum logic [2:0] {
        ST_POLL,
        ST_RESP,
        ST_SNAP,
        ST_PEER,
        ST_VOTE,
        ST_SEND
    } tiv_state_t;

    // =====================================================================
    // Frame check over one data word
    function automatic logic [CRC_W-1:0] crc8(input logic [WORD_W-1:0] data);
        logic [CRC_W-1:0] crc;
        crc = 8'h00;
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            if (crc[CRC_W-1] ^ data[i])
                crc = (crc << 1) ^ CRC_POLY;
            else
                crc = crc << 1;
        end
        return crc;
    endfunction

endpackage

// file: core/tiv_io_bus_if.sv
// Interface for the master-slave I/O bus between a leg and module legs
`timescale 1ns/100ps
`default_nettype none
interface tiv_io_bus_if;

    // =====================================================================
    // Request and answer
    logic                           req;
    logic                           wr;
    logic [tiv_pkg::ADDR_W-1:0]     addr;
    logic [tiv_pkg::WORD_W-1:0]     wdata;
    logic [tiv_pkg::CRC_W-1:0]      wcrc;
    logic                           ack;
    logic [tiv_pkg::WORD_W-1:0]     rdata;
    logic [tiv_pkg::CRC_W-1:0]      rcrc;

    modport master (
        output req,
        output wr,
        output addr,
        output wdata,
        output wcrc,
        input  ack,
        input  rdata,
        input  rcrc
    );

    modport slave (
        input  req,
        input  wr,
        input  addr,
        input  wdata,
        input  wcrc,
        output ack,
        output rdata,
        output rcrc
    );

endinterface
`default_nettype wire

// file: core/tiv_io_leg.sv
// One leg of a triplicated input and output module, slave on the I/O bus
`timescale 1ns/100ps
`default_nettype none
module tiv_io_leg #(
    parameter int WDOG_CYC = tiv_pkg::WDOG_DEFAULT_CYC
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // I/O bus
    tiv_io_bus_if.slave                     bus,
    // Field inputs
    input  wire logic [tiv_pkg::WORD_W-1:0] field_in,
    // Output data table and link state
    output logic [tiv_pkg::WORD_W-1:0]      out_table,
    output logic                            link_up
);

    // =====================================================================
    // Field input synchroniser
    logic [tiv_pkg::WORD_W-1:0]     fsync1;
    logic [tiv_pkg::WORD_W-1:0]     fsync2;
    logic [tiv_pkg::WORD_W-1:0]     fsync3;
    logic [tiv_pkg::WORD_W-1:0]     field_clean;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fsync1      <= 16'h0000;
            fsync2      <= 16'h0000;
            fsync3      <= 16'h0000;
            field_clean <= 16'h0000;
        end
        else
        begin
            fsync1 <= field_in;
            fsync2 <= fsync1;
            fsync3 <= fsync2;
            if (fsync2 == fsync3)
                field_clean <= fsync2;
        end
    end

    // =====================================================================
    // Frame decode
    logic   in_rd;
    logic   out_wr;
    logic   wr_good;

    assign in_rd   = bus.req && !bus.wr && (bus.addr == tiv_pkg::ADDR_IN);
    assign out_wr  = bus.req && bus.wr && (bus.addr == tiv_pkg::ADDR_OUT);
    assign wr_good = out_wr && (bus.wcrc == tiv_pkg::crc8(bus.wdata));

    // =====================================================================
    // Bus answer
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus.ack   <= 1'b0;
            bus.rdata <= 16'h0000;
            bus.rcrc  <= 8'h00;
        end
        else
        begin
            bus.ack <= in_rd || wr_good;
            if (in_rd)
            begin
                bus.rdata <= field_clean;
                bus.rcrc  <= tiv_pkg::crc8(field_clean);
            end
            else if (wr_good)
            begin
                bus.rdata <= bus.wdata;
                bus.rcrc  <= bus.wcrc;
            end
        end
    end

    // =====================================================================
    // Output table, bad frame count and watchdog
    logic [2:0]                     bad_cnt;
    logic [tiv_pkg::WDOG_CNT_W-1:0] wdog;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_table <= tiv_pkg::DEENERGIZED;
            bad_cnt   <= 3'h0;
            wdog      <= 14'h0000;
            link_up   <= 1'b0;
        end
        else if (wr_good)
        begin
            out_table <= bus.wdata;
            bad_cnt   <= 3'h0;
            wdog      <= 14'h0000;
            link_up   <= 1'b1;
        end
        else
        begin
            if (out_wr)
            begin
                if (bad_cnt + 3'h1 >= tiv_pkg::FAIL_LIMIT)
                begin
                    out_table <= tiv_pkg::DEENERGIZED;
                    bad_cnt   <= 3'h0;
                end
                else
                    bad_cnt <= bad_cnt + 3'h1;
            end
            if (link_up)
            begin
                if (wdog == tiv_pkg::WDOG_CNT_W'(WDOG_CYC - 1))
                begin
                    out_table <= tiv_pkg::DEENERGIZED;
                    link_up   <= 1'b0;
                    wdog      <= 14'h0000;
                end
                else
                    wdog <= wdog + 14'h0001;
            end
        end
    end

endmodule
`default_nettype wire

// file: core/tiv_leg_master.sv
// Main processor leg: I/O bus master, snapshot exchange and input voting
`timescale 1ns/100ps
`default_nettype none
module tiv_leg_master (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // I/O bus
    tiv_io_bus_if.master                    bus,
    // Scan synchronization
    input  wire logic                       scan_sync,
    // Peer snapshots
    input  wire logic                       peer_a_tog,
    input  wire logic [tiv_pkg::WORD_W-1:0] peer_a_data,
    input  wire logic [tiv_pkg::CRC_W-1:0]  peer_a_crc,
    input  wire logic                       peer_b_tog,
    input  wire logic [tiv_pkg::WORD_W-1:0] peer_b_data,
    input  wire logic [tiv_pkg::CRC_W-1:0]  peer_b_crc,
    // Own snapshot
    output logic                            snap_tog,
    output logic [tiv_pkg::WORD_W-1:0]      snap_data,
    output logic [tiv_pkg::CRC_W-1:0]       snap_crc,
    // Alarm sources
    input  wire logic [tiv_pkg::ALARM_W-1:0] alarm_src,
    // Voted results and status
    output logic [tiv_pkg::DIG_W-1:0]       voted_dig,
    output logic [tiv_pkg::AN_W-1:0]        voted_an,
    output logic [tiv_pkg::WORD_W-1:0]      out_table,
    output logic                            analog_alarm,
    output logic                            disagree_alarm,
    output logic                            chassis_alarm,
    output logic                            in_fail,
    output logic                            out_fail,
    output logic [1:0]                      peer_fail
);

    // =====================================================================
    // Pin synchronisers
    logic [tiv_pkg::SYN_W-1:0]  sync1;
    logic [tiv_pkg::SYN_W-1:0]  sync2;
    logic [tiv_pkg::SYN_W-1:0]  sync3;
    logic [tiv_pkg::SYN_W-1:0]  clean;
    logic [tiv_pkg::SYN_W-1:0]  clean_d;
    logic [tiv_pkg::SYN_W-1:0]  async_in;
    logic [tiv_pkg::SYN_W-1:0]  change;
    logic                       scan_edge;

    assign async_in  = {alarm_src, peer_b_tog, peer_a_tog, scan_sync};
    assign change    = clean ^ clean_d;
    assign scan_edge = clean[tiv_pkg::SYN_SCAN] && !clean_d[tiv_pkg::SYN_SCAN];

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1   <= '0;
            sync2   <= '0;
            sync3   <= '0;
            clean   <= '0;
            clean_d <= '0;
        end
        else
        begin
            sync1   <= async_in;
            sync2   <= sync1;
            sync3   <= sync2;
            clean   <= (sync2 & ~(sync2 ^ sync3)) | (clean & (sync2 ^ sync3));
            clean_d <= clean;
        end
    end

    // =====================================================================
    // Vote arithmetic
    function automatic logic [tiv_pkg::AN_W-1:0] med3(
        input logic [tiv_pkg::AN_W-1:0] a,
        input logic [tiv_pkg::AN_W-1:0] b,
        input logic [tiv_pkg::AN_W-1:0] c
    );
        logic [tiv_pkg::AN_W-1:0] lo;
        logic [tiv_pkg::AN_W-1:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        if (c < lo)
            return lo;
        else if (c > hi)
            return hi;
        else
            return c;
    endfunction

    logic [tiv_pkg::WORD_W-1:0] leg_own;
    logic [tiv_pkg::WORD_W-1:0] leg_a;
    logic [tiv_pkg::WORD_W-1:0] leg_b;
    logic [tiv_pkg::DIG_W-1:0]  dig_o;
    logic [tiv_pkg::DIG_W-1:0]  dig_a;
    logic [tiv_pkg::DIG_W-1:0]  dig_b;
    logic [tiv_pkg::AN_W-1:0]   an_o;
    logic [tiv_pkg::AN_W-1:0]   an_a;
    logic [tiv_pkg::AN_W-1:0]   an_b;
    logic [tiv_pkg::AN_W-1:0]   an_max;
    logic [tiv_pkg::AN_W-1:0]   an_min;
    logic [tiv_pkg::DIG_W-1:0]  next_dig;
    logic [tiv_pkg::AN_W-1:0]   next_an;
    logic                       dig_mismatch;

    assign dig_o = leg_own[tiv_pkg::DIG_W-1:0];
    assign dig_a = leg_a[tiv_pkg::DIG_W-1:0];
    assign dig_b = leg_b[tiv_pkg::DIG_W-1:0];
    assign an_o  = leg_own[tiv_pkg::WORD_W-1:tiv_pkg::DIG_W];
    assign an_a  = leg_a[tiv_pkg::WORD_W-1:tiv_pkg::DIG_W];
    assign an_b  = leg_b[tiv_pkg::WORD_W-1:tiv_pkg::DIG_W];
    assign next_dig = (dig_o & dig_a) | (dig_o & dig_b) | (dig_a & dig_b);
    assign next_an  = med3(an_o, an_a, an_b);
    assign an_max = (an_o > an_a) ? ((an_o > an_b) ? an_o : an_b) : ((an_a > an_b) ? an_a : an_b);
    assign an_min = (an_o < an_a) ? ((an_o < an_b) ? an_o : an_b) : ((an_a < an_b) ? an_a : an_b);
    assign dig_mismatch = (dig_o != dig_a) || (dig_o != dig_b);

    // =====================================================================
    // Scan request latch
    tiv_pkg::tiv_state_t    state;
    logic                   scan_pend;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            scan_pend <= 1'b0;
        else if (scan_edge)
            scan_pend <= 1'b1;
        else if (state == tiv_pkg::ST_SNAP)
            scan_pend <= 1'b0;
    end

    // =====================================================================
    // Peer arrival flags
    logic   pend_a;
    logic   pend_b;
    logic   got_a;
    logic   got_b;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_a <= 1'b0;
            pend_b <= 1'b0;
        end
        else
        begin
            if (change[tiv_pkg::SYN_PA])
                pend_a <= 1'b1;
            else if (state == tiv_pkg::ST_PEER && !got_a)
                pend_a <= 1'b0;
            if (change[tiv_pkg::SYN_PB])
                pend_b <= 1'b1;
            else if (state == tiv_pkg::ST_PEER && !got_b)
                pend_b <= 1'b0;
        end
    end

    // =====================================================================
    // Sequencer: polling, snapshot, peer exchange, vote, output send
    logic [2:0]     tries;
    logic [7:0]     tmo;
    logic [10:0]    peer_cnt;
    logic [tiv_pkg::WORD_W-1:0] in_table;
    logic           rsp_ok;
    logic           rsp_bad;

    assign rsp_ok  = bus.ack && (bus.wr || bus.rcrc == tiv_pkg::crc8(bus.rdata));
    assign rsp_bad = (bus.ack && !rsp_ok) || (tmo == tiv_pkg::RESP_TIMEOUT_CYC);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= tiv_pkg::ST_POLL;
            bus.req   <= 1'b0;
            bus.wr    <= 1'b0;
            bus.addr  <= tiv_pkg::ADDR_IN;
            bus.wdata <= tiv_pkg::DEENERGIZED;
            bus.wcrc  <= 8'h00;
            tries     <= 3'h0;
            tmo       <= 8'h00;
            peer_cnt  <= 11'h000;
            in_table  <= tiv_pkg::DEENERGIZED;
            leg_own   <= tiv_pkg::DEENERGIZED;
            leg_a     <= tiv_pkg::DEENERGIZED;
            leg_b     <= tiv_pkg::DEENERGIZED;
            got_a     <= 1'b0;
            got_b     <= 1'b0;
            snap_tog  <= 1'b0;
            snap_data <= tiv_pkg::DEENERGIZED;
            snap_crc  <= 8'h00;
            voted_dig <= 8'h00;
            voted_an  <= 8'h00;
            out_table <= tiv_pkg::DEENERGIZED;
            analog_alarm <= 1'b0;
            in_fail   <= 1'b0;
            out_fail  <= 1'b0;
            peer_fail <= 2'h0;
        end
        else
        begin
            bus.req <= 1'b0;
            case (state)
                tiv_pkg::ST_POLL:
                begin
                    bus.req   <= 1'b1;
                    bus.wr    <= 1'b0;
                    bus.addr  <= tiv_pkg::ADDR_IN;
                    bus.wdata <= tiv_pkg::DEENERGIZED;
                    bus.wcrc  <= tiv_pkg::crc8(tiv_pkg::DEENERGIZED);
                    tmo       <= 8'h00;
                    state     <= tiv_pkg::ST_RESP;
                end
                tiv_pkg::ST_SEND:
                begin
                    bus.req   <= 1'b1;
                    bus.wr    <= 1'b1;
                    bus.addr  <= tiv_pkg::ADDR_OUT;
                    bus.wdata <= out_table;
                    bus.wcrc  <= tiv_pkg::crc8(out_table);
                    tmo       <= 8'h00;
                    state     <= tiv_pkg::ST_RESP;
                end
                tiv_pkg::ST_RESP:
                begin
                    tmo <= tmo + 8'h01;
                    if (rsp_ok || (rsp_bad && tries >= tiv_pkg::MAX_RETRY))
                    begin
                        tries <= 3'h0;
                        if (bus.wr)
                        begin
                            out_fail <= !rsp_ok;
                            state    <= tiv_pkg::ST_POLL;
                        end
                        else
                        begin
                            in_table <= rsp_ok ? bus.rdata : tiv_pkg::DEENERGIZED;
                            in_fail  <= !rsp_ok;
                            state    <= scan_pend ? tiv_pkg::ST_SNAP : tiv_pkg::ST_POLL;
                        end
                    end
                    else if (rsp_bad)
                    begin
                        tries <= tries + 3'h1;
                        state <= bus.wr ? tiv_pkg::ST_SEND : tiv_pkg::ST_POLL;
                    end
                end
                tiv_pkg::ST_SNAP:
                begin
                    leg_own   <= in_table;
                    snap_data <= in_table;
                    snap_crc  <= tiv_pkg::crc8(in_table);
                    snap_tog  <= !snap_tog;
                    got_a     <= 1'b0;
                    got_b     <= 1'b0;
                    peer_cnt  <= 11'h000;
                    state     <= tiv_pkg::ST_PEER;
                end
                tiv_pkg::ST_PEER:
                begin
                    peer_cnt <= peer_cnt + 11'h001;
                    if (pend_a && !got_a)
                    begin
                        got_a        <= 1'b1;
                        peer_fail[0] <= peer_a_crc != tiv_pkg::crc8(peer_a_data);
                        leg_a <= (peer_a_crc == tiv_pkg::crc8(peer_a_data)) ?
                                 peer_a_data : tiv_pkg::DEENERGIZED;
                    end
                    if (pend_b && !got_b)
                    begin
                        got_b        <= 1'b1;
                        peer_fail[1] <= peer_b_crc != tiv_pkg::crc8(peer_b_data);
                        leg_b <= (peer_b_crc == tiv_pkg::crc8(peer_b_data)) ?
                                 peer_b_data : tiv_pkg::DEENERGIZED;
                    end
                    if (got_a && got_b)
                        state <= tiv_pkg::ST_VOTE;
                    else if (peer_cnt == tiv_pkg::PEER_TIMEOUT_CYC)
                    begin
                        if (!got_a)
                        begin
                            leg_a        <= tiv_pkg::DEENERGIZED;
                            peer_fail[0] <= 1'b1;
                        end
                        if (!got_b)
                        begin
                            leg_b        <= tiv_pkg::DEENERGIZED;
                            peer_fail[1] <= 1'b1;
                        end
                        state <= tiv_pkg::ST_VOTE;
                    end
                end
                tiv_pkg::ST_VOTE:
                begin
                    voted_dig    <= next_dig;
                    voted_an     <= next_an;
                    out_table    <= {next_an, next_dig};
                    analog_alarm <= (an_max - an_min) > tiv_pkg::AN_DEV_LIMIT;
                    tries        <= 3'h0;
                    state        <= tiv_pkg::ST_SEND;
                end
                default:
                    state <= tiv_pkg::ST_POLL;
            endcase
        end
    end

    // =====================================================================
    // Persistent disagreement
    logic [3:0] persist;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            persist        <= 4'h0;
            disagree_alarm <= 1'b0;
        end
        else if (state == tiv_pkg::ST_VOTE)
        begin
            if (!dig_mismatch)
            begin
                persist        <= 4'h0;
                disagree_alarm <= 1'b0;
            end
            else if (persist + 4'h1 >= tiv_pkg::PERSIST_SCANS)
            begin
                persist        <= tiv_pkg::PERSIST_SCANS;
                disagree_alarm <= 1'b1;
            end
            else
                persist <= persist + 4'h1;
        end
    end

    // =====================================================================
    // Chassis alarm
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            chassis_alarm <= 1'b0;
        else
            chassis_alarm <= (|clean[tiv_pkg::SYN_ALM +: tiv_pkg::ALARM_W]) || in_fail
                             || out_fail || (|peer_fail) || disagree_alarm;
    end

endmodule
`default_nettype wire

// file: tb/tiv_bus_assertions.sv
// Concurrent checks on the I/O bus between a leg and a module leg
`timescale 1ns/100ps
`default_nettype none
module tiv_bus_assertions (
    // Clock and reset
    input wire logic                       clk_sys,
    input wire logic                       reset_n,
    // Bus signals
    input wire logic                       req,
    input wire logic                       wr,
    input wire logic [tiv_pkg::ADDR_W-1:0] addr,
    input wire logic [tiv_pkg::WORD_W-1:0] wdata,
    input wire logic [tiv_pkg::CRC_W-1:0]  wcrc,
    input wire logic                       ack,
    input wire logic [tiv_pkg::WORD_W-1:0] rdata,
    input wire logic [tiv_pkg::CRC_W-1:0]  rcrc
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // =====================================================================
    // Bus handshake
    sequence s_read_req;
        req && !wr;
    endsequence
    sequence s_ack_next;
        ##1 ack;
    endsequence
    a_read_acked: assert property (s_read_req |-> s_ack_next)
        else $error("read request not answered");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("answer without request");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_req_spacing: assert property (req |=> !req [*2])
        else $error("requests too close");
    a_read_addr: assert property (s_read_req |-> addr == tiv_pkg::ADDR_IN)
        else $error("read not aimed at input leg");
    a_write_addr: assert property (req && wr |-> addr == tiv_pkg::ADDR_OUT)
        else $error("write not aimed at output leg");
    a_ctl_hold: assert property (!req |-> $stable({wr, addr, wdata, wcrc}))
        else $error("request fields moved between requests");
    a_rdata_hold: assert property (!ack |-> $stable({rdata, rcrc}))
        else $error("read word moved between answers");
endmodule
`default_nettype wire

// file: tb/tmr_input_vote_io_exchange_tb_top.sv
// Bench joining a main processor leg to a module leg over the I/O bus
`timescale 1ns/100ps
`default_nettype none
module tmr_input_vote_io_exchange_tb_top;
    // =====================================================================
    // Signals
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        scan_sync = 1'b0;
    logic        peer_a_tog = 1'b0;
    logic        peer_b_tog = 1'b0;
    logic [15:0] peer_a_data = 16'h0000;
    logic [15:0] peer_b_data = 16'h0000;
    logic [7:0]  peer_a_crc = 8'h00;
    logic [7:0]  peer_b_crc = 8'h00;
    logic [5:0]  alarm_src = 6'h00;
    logic [15:0] field_in = 16'h0000;
    logic [7:0]  voted_dig, voted_an;
    logic [15:0] m_out, s_out, snap_data;
    logic [1:0]  peer_fail;
    logic        snap_tog, analog_alarm, chassis_alarm, link_up, in_fail, out_fail;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #5 clk_sys = ~clk_sys;
    tiv_io_bus_if bus ();
    tiv_leg_master u_tiv_leg_master (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
        .scan_sync(scan_sync), .peer_a_tog(peer_a_tog), .peer_a_data(peer_a_data),
        .peer_a_crc(peer_a_crc), .peer_b_tog(peer_b_tog), .peer_b_data(peer_b_data),
        .peer_b_crc(peer_b_crc), .snap_tog(snap_tog), .snap_data(snap_data), .snap_crc(),
        .alarm_src(alarm_src), .voted_dig(voted_dig), .voted_an(voted_an), .out_table(m_out),
        .analog_alarm(analog_alarm), .disagree_alarm(), .chassis_alarm(chassis_alarm),
        .in_fail(in_fail), .out_fail(out_fail), .peer_fail(peer_fail));
    tiv_io_leg #(.WDOG_CYC(3000)) u_tiv_io_leg (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus(bus), .field_in(field_in), .out_table(s_out), .link_up(link_up));
    tiv_bus_assertions u_tiv_bus_assertions (.clk_sys(clk_sys), .reset_n(reset_n),
        .req(bus.req), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .wcrc(bus.wcrc),
        .ack(bus.ack), .rdata(bus.rdata), .rcrc(bus.rcrc));
    // =====================================================================
    // Helpers
    function automatic logic [7:0] f_crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = (c[7] ^ d[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
        return c;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run_scan(input logic [15:0] own, pa, pb, input logic bad_b);
        logic t;
        int   n;
        repeat (2200) @(posedge clk_sys);
        field_in <= own;
        peer_a_data <= pa;
        peer_a_crc <= f_crc(pa);
        peer_b_data <= pb;
        peer_b_crc <= f_crc(pb) ^ 8'(bad_b);
        repeat (40) @(posedge clk_sys);
        scan_sync <= 1'b1;
        t = snap_tog;
        for (n = 0; n < 100 && snap_tog === t; n++) @(negedge clk_sys);
        check(16'(snap_tog !== t), 16'h0001);
        @(posedge clk_sys);
        peer_a_tog <= ~peer_a_tog;
        peer_b_tog <= ~peer_b_tog;
        scan_sync <= 1'b0;
        for (n = 0; n < 3000 && !(bus.req === 1'b1 && bus.wr === 1'b1); n++) @(negedge clk_sys);
        check(16'(n < 3000), 16'h0001);
        repeat (3) @(negedge clk_sys);
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            $display("FAIL %0t run did not finish", $time);
            stop_test;
        end
    end
    // =====================================================================
    // Tests
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        run_scan(16'h40C3, 16'h48A5, 16'h200F, 1'b0);
        check(voted_dig, 16'h0087);
        check(snap_data, 16'h40C3);
        check(16'({in_fail, out_fail}), 16'h0000);
        check(voted_an, 16'h0040);
        check(16'(analog_alarm), 16'h0001);
        check(s_out, 16'h4087);
        check(16'(link_up), 16'h0001);
        $display("test 1 done");
        run_scan(16'h40C3, 16'h48A5, 16'h200F, 1'b1);
        check(voted_dig, 16'h0081);
        check(16'(peer_fail), 16'h0002);
        check(16'(chassis_alarm), 16'h0001);
        check(m_out, 16'h4081);
        $display("test 2 done");
        run_scan(16'h40C3, 16'h42C3, 16'h3FC3, 1'b0);
        check(m_out, 16'h40C3);
        check(16'(analog_alarm), 16'h0000);
        check(16'(chassis_alarm), 16'h0000);
        $display("test 3 done");
        repeat (3100) @(posedge clk_sys);
        check(s_out, 16'h0000);
        check(16'(link_up), 16'h0000);
        alarm_src <= 6'h04;
        repeat (8) @(negedge clk_sys);
        check(16'(chassis_alarm), 16'h0001);
        $display("test 4 done");
        stop_test;
    end
endmodule
`default_nettype wire
